// ==== hw/gpmc_port.sv ====
// Purpose: one general-purpose port, pin mode control and overrides
// Assumes: registers written as whole words through reg_wr/reg_sel
// Notes:   every pad control leaves a flop, so pads lag config by one cycle
// Operation
// [R1] input mode: schmitt on, driver off, sample pin
// [R2] pulls connect only as pull field selects
// [R3] open-drain: drive low on 0, float on 1
// [R4] push-pull: drive pin to output data bit
// [R5] output mode still samples; data reads back written
// [R6] alternate mode: peripheral drives, pin still sampled
// [R7] analog: schmitt, pulls, driver off; input reads 0
// [R8] reset puts ordinary pins analog, no alternate
// [R9] debug pins reset with their documented pulls
// [R10] boot pin pull-down; reset pin not general-purpose
// [R11] set and clear writes touch only one bits
// [R12] software uses input mode for interrupt pins
// [R13] software programs select and type before alternate
// [R14] software sets clock output pin alternate push-pull
// [R15] crystal enable forces oscillator pins analog
// [R16] timestamp enable with select nine floats pins
// [R17] standby pulls low-power pins down
// [R18] running oscillator forces its pins analog
// [R19] debug signals sit on alternate zero
// [R20] debug configuration frees debug pins
// [R21] injected trigger from lines or timer8 channel4
// [R22] regular trigger from lines or timer8 trigger
// [R23] software uses full-word register accesses only
// [R24] alternate mux routes peripheral picked by select
`timescale 1ns/1ps
module gpmc_port
    import gpmc_pkg::*;
#(
    parameter logic [1:0] PORT_ID = GPMC_PORT_A
) (
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic          reg_wr,
    input  gpmc_reg_sel_t      reg_sel,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic [15:0]   pin_in,
    input  wire logic [255:0]  af_out,
    input  wire logic [255:0]  af_oe,
    input  wire logic          low_speed_osc_enable,
    input  wire logic          low_speed_osc_bypass,
    input  wire logic          high_speed_osc_enable,
    input  wire logic          high_speed_osc_bypass,
    input  wire logic          rtc_timestamp_enable,
    input  wire logic          standby,
    input  wire logic          rtc_owns_pc13,
    input  wire logic [1:0]    debug_config,
    input  wire logic          injected_trigger_remap,
    input  wire logic          regular_trigger_remap,
    input  wire logic          external_interrupt_lines_inj_trig,
    input  wire logic          external_interrupt_lines_reg_trig,
    input  wire logic          timer8_channel4,
    input  wire logic          timer8_trigger_out,
    output logic [15:0]        pin_out,
    output logic [15:0]        pin_oe,
    output logic [15:0]        pull_up_en,
    output logic [15:0]        pull_dn_en,
    output logic [15:0]        schmitt_en,
    output logic [15:0]        input_data_reg,
    output logic [31:0]        pin_mode_reg,
    output logic [15:0]        output_type_reg,
    output logic [31:0]        pull_config_reg,
    output logic [15:0]        output_data_reg,
    output logic [31:0]        alt_select_low_reg,
    output logic [31:0]        alt_select_high_reg,
    output logic               rtc_timestamp_in,
    output logic               boot_pull_dn_en,
    output logic               adc_inj_trig,
    output logic               adc_reg_trig
);

    logic        wr_mode, wr_otype, wr_pull, wr_odata, wr_bset, wr_bclr, wr_afl, wr_afh;
    logic [31:0] mode_rst, pull_rst;
    logic [63:0] af_sel_all;
    logic [15:0] dbg_freed;
    logic [15:0] out_nxt, oe_nxt, pu_nxt, pd_nxt, sch_nxt;
    logic [15:0] an_mask, in_mask, od_mask, pp_out_mask;
    logic        ts_nxt;

    assign wr_mode  = reg_wr && (reg_sel == GPMC_SEL_MODE);
    assign wr_otype = reg_wr && (reg_sel == GPMC_SEL_OTYPE);
    assign wr_pull  = reg_wr && (reg_sel == GPMC_SEL_PULL);
    assign wr_odata = reg_wr && (reg_sel == GPMC_SEL_ODATA);
    assign wr_bset  = reg_wr && (reg_sel == GPMC_SEL_BSET);
    assign wr_bclr  = reg_wr && (reg_sel == GPMC_SEL_BCLR);
    assign wr_afl   = reg_wr && (reg_sel == GPMC_SEL_AFL);
    assign wr_afh   = reg_wr && (reg_sel == GPMC_SEL_AFH);

    // debug pins on ports a and b wake up owned by the debug unit
    assign mode_rst = (PORT_ID == GPMC_PORT_A) ? GPMC_MODE_RST_A :   // see [R8] [R9]
                      (PORT_ID == GPMC_PORT_B) ? GPMC_MODE_RST_B : GPMC_MODE_RST;
    assign pull_rst = (PORT_ID == GPMC_PORT_A) ? GPMC_PULL_RST_A :   // see [R9]
                      (PORT_ID == GPMC_PORT_B) ? GPMC_PULL_RST_B : GPMC_PULL_RST;
    assign af_sel_all = {alt_select_high_reg, alt_select_low_reg};

    // configuration words, full-word writes only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_mode_reg    <= mode_rst;                        // see [R8]
            pull_config_reg <= pull_rst;
        end else begin
            if (wr_mode) pin_mode_reg <= reg_wdata;
            if (wr_pull) pull_config_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            output_type_reg     <= GPMC_HALF_RST;
            alt_select_low_reg  <= GPMC_WORD_RST;                // see [R8]
            alt_select_high_reg <= GPMC_WORD_RST;
        end else begin
            if (wr_otype) output_type_reg <= reg_wdata[15:0];
            if (wr_afl) alt_select_low_reg <= reg_wdata;
            if (wr_afh) alt_select_high_reg <= reg_wdata;
        end
    end

    // output data: write, set or clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            output_data_reg <= GPMC_HALF_RST;
        end else if (wr_odata) begin
            output_data_reg <= reg_wdata[15:0];                  // see [R5]
        end else if (wr_bset) begin
            output_data_reg <= output_data_reg | reg_wdata[15:0];   // see [R11]
        end else if (wr_bclr) begin
            output_data_reg <= output_data_reg & ~reg_wdata[15:0];  // see [R11]
        end
    end

    // debug pins released by the debug configuration
    always_comb begin
        dbg_freed = '0;
        if (PORT_ID == GPMC_PORT_B && debug_config != GPMC_DBG_FULL) begin
            dbg_freed[GPMC_PIN_TRST] = 1'b1;                     // see [R20]
        end
        if (debug_config == GPMC_DBG_SWONLY || debug_config == GPMC_DBG_OFF) begin
            if (PORT_ID == GPMC_PORT_A) dbg_freed[GPMC_PIN_TDI] = 1'b1;
            if (PORT_ID == GPMC_PORT_B) dbg_freed[GPMC_PIN_TDO] = 1'b1;
        end
        if (PORT_ID == GPMC_PORT_A && debug_config == GPMC_DBG_OFF) begin
            dbg_freed[GPMC_PIN_TMS] = 1'b1;
            dbg_freed[GPMC_PIN_TCK] = 1'b1;
        end
    end

    // per-pin mode after overrides
    always_comb begin
        logic [1:0] md;
        logic [1:0] pl;
        logic [3:0] sel;
        logic       af_o;
        logic       af_e;
        logic       f_an;
        logic       f_fl;
        logic       f_pd;
        md = GPMC_MODE_AN;
        pl = GPMC_PULL_NONE;
        sel = GPMC_AF_DEBUG;
        af_o = 1'b0;
        af_e = 1'b0;
        f_an = 1'b0;
        f_fl = 1'b0;
        f_pd = 1'b0;
        out_nxt = '0;
        oe_nxt = '0;
        pu_nxt = '0;
        pd_nxt = '0;
        sch_nxt = '0;
        an_mask = '0;
        in_mask = '0;
        od_mask = '0;
        pp_out_mask = '0;
        ts_nxt = 1'b0;
        for (int i = 0; i < GPMC_PINS; i++) begin
            md = pin_mode_reg[2*i +: 2];
            pl = pull_config_reg[2*i +: 2];
            sel = af_sel_all[4*i +: 4];
            af_o = af_out[i*GPMC_AF_NUM + int'(sel)];            // see [R24]
            af_e = af_oe[i*GPMC_AF_NUM + int'(sel)];
            // a freed debug pin no longer follows the debug unit
            if (sel == GPMC_AF_DEBUG && dbg_freed[i]) af_e = 1'b0; // see [R19] [R20]
            f_an = 1'b0;
            f_fl = 1'b0;
            f_pd = 1'b0;
            // priority: crystal, then timestamp, then standby
            if (PORT_ID == GPMC_PORT_C && (i == GPMC_PIN_OSCI || i == GPMC_PIN_OSCO)) begin
                if (low_speed_osc_enable) begin
                    f_an = (i == GPMC_PIN_OSCI) || !low_speed_osc_bypass;  // see [R15]
                end else if (rtc_timestamp_enable && sel == GPMC_AF_TSTAMP) begin
                    f_fl = 1'b1;                                 // see [R16]
                end else if (standby) begin
                    f_pd = 1'b1;                                 // see [R17]
                end
            end
            if (PORT_ID == GPMC_PORT_C && i == GPMC_PIN_RTC) begin
                f_pd = standby && !rtc_owns_pc13;                // see [R17]
            end
            if (PORT_ID == GPMC_PORT_D && (i == GPMC_PIN_OSCI || i == GPMC_PIN_OSCO)) begin
                f_an = high_speed_osc_enable &&
                       ((i == GPMC_PIN_OSCI) || !high_speed_osc_bypass);   // see [R18]
            end
            if (f_an) begin
                md = GPMC_MODE_AN;
            end else if (f_fl || f_pd) begin
                md = GPMC_MODE_IN;
                pl = f_pd ? GPMC_PULL_DN : GPMC_PULL_NONE;
            end
            unique case (md)
                GPMC_MODE_IN: begin
                    oe_nxt[i] = 1'b0;                            // see [R1]
                    in_mask[i] = 1'b1;
                end
                GPMC_MODE_OUT: begin
                    if (output_type_reg[i]) begin
                        oe_nxt[i] = !output_data_reg[i];         // see [R3]
                        od_mask[i] = 1'b1;
                    end else begin
                        oe_nxt[i] = 1'b1;                        // see [R4]
                        out_nxt[i] = output_data_reg[i];
                        pp_out_mask[i] = 1'b1;
                    end
                end
                GPMC_MODE_AF: begin
                    if (output_type_reg[i]) begin
                        oe_nxt[i] = af_e && !af_o;               // see [R6]
                        od_mask[i] = 1'b1;
                    end else begin
                        oe_nxt[i] = af_e;                        // see [R6]
                        out_nxt[i] = af_o;
                    end
                end
                GPMC_MODE_AN: begin
                    an_mask[i] = 1'b1;                           // see [R7]
                end
            endcase
            sch_nxt[i] = (md != GPMC_MODE_AN);                   // see [R1] [R7]
            pu_nxt[i] = sch_nxt[i] && (pl == GPMC_PULL_UP);      // see [R2]
            pd_nxt[i] = sch_nxt[i] && (pl == GPMC_PULL_DN);      // see [R2]
            if (f_fl) ts_nxt = ts_nxt | pin_in[i];               // see [R16]
        end
    end

    // pad controls leave flops; pads idle analog during reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_out    <= GPMC_HALF_RST;
            pin_oe     <= GPMC_HALF_RST;
            pull_up_en <= GPMC_HALF_RST;
            pull_dn_en <= GPMC_HALF_RST;
            schmitt_en <= GPMC_HALF_RST;
        end else begin
            pin_out    <= out_nxt;
            pin_oe     <= oe_nxt;
            pull_up_en <= pu_nxt;
            pull_dn_en <= pd_nxt;
            schmitt_en <= sch_nxt;
        end
    end

    // input sampling, zero with schmitt off
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            input_data_reg   <= GPMC_HALF_RST;
            rtc_timestamp_in <= 1'b0;
        end else begin
            input_data_reg   <= pin_in & sch_nxt;                // see [R1] [R5] [R7]
            rtc_timestamp_in <= ts_nxt;
        end
    end

    // boot select keeps its pull-down; reset pin has no port bit here
    always_ff @(posedge ref_clk) begin
        if (reset) boot_pull_dn_en <= 1'b1;                      // see [R10]
        else boot_pull_dn_en <= 1'b1;
    end

    // adc trigger source selection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            adc_inj_trig <= 1'b0;
            adc_reg_trig <= 1'b0;
        end else begin
            adc_inj_trig <= injected_trigger_remap ? timer8_channel4 : external_interrupt_lines_inj_trig; // see [R21]
            adc_reg_trig <= regular_trigger_remap ? timer8_trigger_out : external_interrupt_lines_reg_trig; // see [R22]
        end
    end

    chk_analog_reads_zero: assert property ( // see [R7]
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> ((input_data_reg | pin_oe | pull_up_en | pull_dn_en) & $past(an_mask)) == '0)
        else $error("analog pin active");

    chk_od_never_high: assert property ( // see [R3]
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> (pin_out & $past(od_mask)) == '0)
        else $error("open-drain pin driven high");

    chk_pp_follows_data: assert property ( // see [R4]
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> ((pin_oe & $past(pp_out_mask)) == $past(pp_out_mask)) &&
                 ((pin_out ^ $past(output_data_reg)) & $past(pp_out_mask)) == '0)
        else $error("push-pull level wrong");

    chk_input_no_drive: assert property ( // see [R1]
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> (pin_oe & $past(in_mask)) == '0 &&
                 ((input_data_reg ^ $past(pin_in)) & $past(in_mask)) == '0)
        else $error("input pin wrong");

    chk_bit_set: assert property ( // see [R11]
        @(posedge ref_clk) disable iff (reset)
        wr_bset |=> output_data_reg == ($past(output_data_reg) | $past(reg_wdata[15:0])))
        else $error("bit set write wrong");

    chk_bit_clear: assert property ( // see [R11]
        @(posedge ref_clk) disable iff (reset)
        wr_bclr |=> output_data_reg == ($past(output_data_reg) & ~$past(reg_wdata[15:0])))
        else $error("bit clear write wrong");

    chk_reset_state: assert property ( // see [R8]
        @(posedge ref_clk)
        $fell(reset) |-> pin_mode_reg == mode_rst && alt_select_low_reg == '0 &&
                         alt_select_high_reg == '0 && pin_oe == '0)
        else $error("reset state wrong");

    chk_inj_trigger: assert property ( // see [R21]
        @(posedge ref_clk) disable iff (reset)
        injected_trigger_remap ##1 !reset |-> adc_inj_trig == $past(timer8_channel4))
        else $error("injected trigger wrong");

    chk_reg_trigger: assert property ( // see [R22]
        @(posedge ref_clk) disable iff (reset)
        !regular_trigger_remap ##1 !reset |-> adc_reg_trig == $past(external_interrupt_lines_reg_trig))
        else $error("regular trigger wrong");

endmodule : gpmc_port

// ==== pkg/gpmc_pkg.sv ====
// Purpose: constants and types shared by the pin mode control block
// Assumes: one 16-pin port per instance, 4-bit alternate select per pin
// Notes:   mode, pull and debug-config codes follow the pin field layout
package gpmc_pkg;

    localparam int          GPMC_PINS      = 16;
    localparam int          GPMC_AF_NUM    = 16;

    // pin mode field codes
    localparam logic [1:0]  GPMC_MODE_IN   = 2'h0;
    localparam logic [1:0]  GPMC_MODE_OUT  = 2'h1;
    localparam logic [1:0]  GPMC_MODE_AF   = 2'h2;
    localparam logic [1:0]  GPMC_MODE_AN   = 2'h3;

    // pull field codes, 2'h3 is reserved and connects nothing
    localparam logic [1:0]  GPMC_PULL_NONE = 2'h0;
    localparam logic [1:0]  GPMC_PULL_UP   = 2'h1;
    localparam logic [1:0]  GPMC_PULL_DN   = 2'h2;

    // alternate function codes with fixed meaning
    localparam logic [3:0]  GPMC_AF_DEBUG  = 4'h0;
    localparam logic [3:0]  GPMC_AF_TSTAMP = 4'h9;

    // port identities
    localparam logic [1:0]  GPMC_PORT_A    = 2'h0;
    localparam logic [1:0]  GPMC_PORT_B    = 2'h1;
    localparam logic [1:0]  GPMC_PORT_C    = 2'h2;
    localparam logic [1:0]  GPMC_PORT_D    = 2'h3;

    // pin positions
    localparam int          GPMC_PIN_TMS   = 13;
    localparam int          GPMC_PIN_TCK   = 14;
    localparam int          GPMC_PIN_TDI   = 15;
    localparam int          GPMC_PIN_TDO   = 3;
    localparam int          GPMC_PIN_TRST  = 4;
    localparam int          GPMC_PIN_RTC   = 13;
    localparam int          GPMC_PIN_OSCI  = 14;
    localparam int          GPMC_PIN_OSCO  = 15;

    // debug port configurations
    localparam logic [1:0]  GPMC_DBG_FULL  = 2'h0;
    localparam logic [1:0]  GPMC_DBG_NOTRST = 2'h1;
    localparam logic [1:0]  GPMC_DBG_SWONLY = 2'h2;
    localparam logic [1:0]  GPMC_DBG_OFF   = 2'h3;

    // values after reset
    localparam logic [31:0] GPMC_MODE_RST   = 32'hFFFF_FFFF;
    localparam logic [31:0] GPMC_MODE_RST_A = 32'hABFF_FFFF;
    localparam logic [31:0] GPMC_MODE_RST_B = 32'hFFFF_FEBF;
    localparam logic [31:0] GPMC_PULL_RST   = 32'h0000_0000;
    localparam logic [31:0] GPMC_PULL_RST_A = 32'h6400_0000;
    localparam logic [31:0] GPMC_PULL_RST_B = 32'h0000_0100;
    localparam logic [31:0] GPMC_WORD_RST   = 32'h0000_0000;
    localparam logic [15:0] GPMC_HALF_RST   = 16'h0000;

    // which register a write targets
    typedef enum logic [2:0] {
        GPMC_SEL_MODE,
        GPMC_SEL_OTYPE,
        GPMC_SEL_PULL,
        GPMC_SEL_ODATA,
        GPMC_SEL_BSET,
        GPMC_SEL_BCLR,
        GPMC_SEL_AFL,
        GPMC_SEL_AFH
    } gpmc_reg_sel_t;

endpackage : gpmc_pkg

// ==== test/gpmc_board.sv ====
// Purpose: board side of one port
// Assumes: the bench never drives a pin that the device drives
// Notes:   an undriven, unpulled pin toggles every cycle
`timescale 1ns/1ps
module gpmc_board (
    input  wire logic        ref_clk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] pull_up_en,
    input  wire logic [15:0] pull_dn_en,
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    output logic      [15:0] pin_in
);
    logic [15:0] float_r = 16'h5555;

    // floating pins toggle, no stale level
    always_ff @(posedge ref_clk) begin
        float_r <= ~float_r;
    end

    // device drive wins, then the board, then the pulls
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) |
                    (~ext_en & (pull_up_en | (~pull_dn_en & float_r)))));
endmodule : gpmc_board

// ==== test/gpmc_port_tb.sv ====
// Purpose: bench for the pin mode control port
// Assumes: pads lag a register write by one edge, input data by two
// Notes:   port A carries three of the five debug pins, port C the low-power pins
`timescale 1ns/1ps
module gpmc_port_tb
    import gpmc_pkg::*;
();
    logic            ref_clk, reset, reg_wr;
    gpmc_reg_sel_t   reg_sel;
    logic [31:0]     reg_wdata, pin_mode_reg, pin_mode_reg_c, pull_config_reg;
    logic [255:0]    af_out, af_oe;
    logic            low_speed_osc_enable, low_speed_osc_bypass, rtc_timestamp_enable;
    logic            standby, rtc_owns_pc13, injected_trigger_remap, regular_trigger_remap;
    logic            external_interrupt_lines_inj_trig, external_interrupt_lines_reg_trig, timer8_channel4, timer8_trigger_out;
    logic [1:0]      debug_config;
    logic [15:0]     ext_en, ext_val, pin_in, pin_in_c, pin_out, pin_oe, output_data_reg;
    logic [15:0]     pull_up_en, pull_dn_en, schmitt_en, input_data_reg;
    logic [15:0]     pull_up_en_c, pull_dn_en_c, schmitt_en_c;
    logic            boot_pull_dn_en, adc_inj_trig, adc_reg_trig, rtc_timestamp_in_c;
    int              bad_count, comparisons;
    logic [2:0]      exp_oe [4] = '{3'b111, 3'b111, 3'b011, 3'b000};

    gpmc_port #(.PORT_ID(GPMC_PORT_A)) u_gpmc_port (
        .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .pin_in(pin_in), .af_out(af_out), .af_oe(af_oe),
        .low_speed_osc_enable(low_speed_osc_enable), .low_speed_osc_bypass(low_speed_osc_bypass),
        .high_speed_osc_enable(1'b0), .high_speed_osc_bypass(1'b0),
        .rtc_timestamp_enable(rtc_timestamp_enable), .standby(standby),
        .rtc_owns_pc13(rtc_owns_pc13), .debug_config(debug_config),
        .injected_trigger_remap(injected_trigger_remap), .external_interrupt_lines_inj_trig(external_interrupt_lines_inj_trig),
        .regular_trigger_remap(regular_trigger_remap), .external_interrupt_lines_reg_trig(external_interrupt_lines_reg_trig),
        .timer8_channel4(timer8_channel4), .timer8_trigger_out(timer8_trigger_out),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
        .schmitt_en(schmitt_en), .input_data_reg(input_data_reg), .pin_mode_reg(pin_mode_reg),
        .output_type_reg(), .pull_config_reg(pull_config_reg),
        .output_data_reg(output_data_reg), .alt_select_low_reg(), .alt_select_high_reg(),
        .rtc_timestamp_in(), .boot_pull_dn_en(boot_pull_dn_en),
        .adc_inj_trig(adc_inj_trig), .adc_reg_trig(adc_reg_trig)
    );

    gpmc_port #(.PORT_ID(GPMC_PORT_C)) u_gpmc_port_c (
        .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .pin_in(pin_in_c), .af_out(af_out), .af_oe(af_oe),
        .low_speed_osc_enable(low_speed_osc_enable), .low_speed_osc_bypass(low_speed_osc_bypass),
        .high_speed_osc_enable(1'b0), .high_speed_osc_bypass(1'b0),
        .rtc_timestamp_enable(rtc_timestamp_enable), .standby(standby),
        .rtc_owns_pc13(rtc_owns_pc13), .debug_config(debug_config),
        .injected_trigger_remap(injected_trigger_remap), .external_interrupt_lines_inj_trig(external_interrupt_lines_inj_trig),
        .regular_trigger_remap(regular_trigger_remap), .external_interrupt_lines_reg_trig(external_interrupt_lines_reg_trig),
        .timer8_channel4(timer8_channel4), .timer8_trigger_out(timer8_trigger_out),
        .pin_out(), .pin_oe(), .pull_up_en(pull_up_en_c), .pull_dn_en(pull_dn_en_c),
        .schmitt_en(schmitt_en_c), .input_data_reg(), .pin_mode_reg(pin_mode_reg_c),
        .output_type_reg(), .pull_config_reg(), .output_data_reg(), .alt_select_low_reg(),
        .alt_select_high_reg(), .rtc_timestamp_in(rtc_timestamp_in_c), .boot_pull_dn_en(),
        .adc_inj_trig(), .adc_reg_trig()
    );

    gpmc_board u_gpmc_board (
        .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
    );

    // 50 ns period
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk32

    // narrow results share the word compare
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        chk32({16'h0000, got}, {16'h0000, exp});
    endtask : chk16

    // strobe stays high so back-to-back writes need no idle edge
    task automatic wr(input gpmc_reg_sel_t sel, input logic [31:0] data);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = data;
        @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic tick(input int n);
        reg_wr = 1'b0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : tick

    task automatic t_reset();
        chk32(pin_mode_reg, 32'hABFF_FFFF);
        chk32(pin_mode_reg_c, 32'hFFFF_FFFF);
        chk32(pull_config_reg, 32'h6400_0000);
        chk16(pull_up_en, 16'hA000);
        chk16(pull_dn_en, 16'h4000);
        chk16(schmitt_en, 16'hE000);
        chk16(input_data_reg, 16'hA000);
        chk16(pin_oe | output_data_reg, 16'h0000);
        chk16(schmitt_en_c, 16'h0000);
        chk16({15'h0, boot_pull_dn_en}, 16'h0001);
    endtask : t_reset

    // pin0 driven, pin1 up, pin2 down, pin3 floats
    task automatic t_input();
        ext_en = 16'h0001;
        ext_val = 16'h0001;
        wr(GPMC_SEL_MODE, 32'hFFFF_FF00);
        wr(GPMC_SEL_PULL, 32'h0000_0024);
        tick(3);
        chk16(input_data_reg & 16'hFFF7, 16'h0003);
        chk16(schmitt_en, 16'h000F);
        chk16(pin_oe, 16'h0000);
        chk16(pull_up_en, 16'h0002);
        chk16(pull_dn_en, 16'h0004);
    endtask : t_input

    // pin4 push-pull, pin5 open-drain
    task automatic t_output();
        wr(GPMC_SEL_MODE, 32'hFFFF_F5FF);
        wr(GPMC_SEL_OTYPE, 32'h0000_0020);
        wr(GPMC_SEL_ODATA, 32'h0000_0000);
        tick(3);
        chk16(pin_oe & 16'h0030, 16'h0030);
        chk16(pin_out & 16'h0030, 16'h0000);
        wr(GPMC_SEL_BSET, 32'h0000_0030);
        tick(3);
        chk16(pin_oe & 16'h0030, 16'h0010);
        chk16(pin_out & 16'h0010, 16'h0010);
        chk16(input_data_reg & 16'h0010, 16'h0010);
        chk16(output_data_reg, 16'h0030);
    endtask : t_output

    task automatic t_setclr();
        wr(GPMC_SEL_ODATA, 32'h0000_00F0);
        wr(GPMC_SEL_BSET, 32'h0000_0101);
        wr(GPMC_SEL_BCLR, 32'h0000_0030);
        tick(1);
        chk16(output_data_reg, 16'h01C1);
    endtask : t_setclr

    // pin8 clock out: type, select, then mode
    task automatic t_alt();
        {af_out[131], af_oe[131]} = 2'b11;
        wr(GPMC_SEL_OTYPE, 32'h0000_0000);
        wr(GPMC_SEL_AFH, 32'h0000_0003);
        wr(GPMC_SEL_MODE, 32'hFFFE_FFFF);
        tick(3);
        chk16(pin_oe & pin_out & 16'h0100, 16'h0100);
        chk16(input_data_reg & 16'h0100, 16'h0100);
        wr(GPMC_SEL_AFH, 32'h0000_0005);
        tick(3);
        chk16(pin_oe & 16'h0100, 16'h0000);
    endtask : t_alt

    task automatic t_analog();
        wr(GPMC_SEL_MODE, 32'hFFFF_FFFF);
        wr(GPMC_SEL_PULL, 32'h5555_5555);
        tick(3);
        chk32(pin_mode_reg, 32'hFFFF_FFFF);
        chk16(input_data_reg | schmitt_en, 16'h0000);
        chk16(pull_up_en | pin_oe, 16'h0000);
    endtask : t_analog

    // every debug configuration
    task automatic t_debug();
        {af_oe[240], af_oe[224], af_oe[208]} = 3'b111;
        wr(GPMC_SEL_MODE, 32'hABFF_FFFF);
        wr(GPMC_SEL_AFH, 32'h0000_0000);
        for (int c = 0; c < 4; c++) begin
            debug_config = c[1:0];
            tick(3);
            chk16(pin_oe & 16'hE000, {exp_oe[c], 13'h0000});
        end
    endtask : t_debug

    // both remap settings, both source levels
    task automatic t_trig();
        for (int k = 0; k < 4; k++) begin
            {injected_trigger_remap, regular_trigger_remap} = {2{k[1]}};
            {external_interrupt_lines_inj_trig, external_interrupt_lines_reg_trig} = {2{k[0]}};
            {timer8_channel4, timer8_trigger_out} = {2{~k[0]}};
            tick(2);
            chk16({15'h0, adc_inj_trig}, {15'h0, k[1] ^ k[0]});
            chk16({15'h0, adc_reg_trig}, {15'h0, k[1] ^ k[0]});
        end
    endtask : t_trig

    // port C low-power pins as inputs
    task automatic t_portc();
        pin_in_c = 16'h4000;
        low_speed_osc_enable = 1'b1;
        wr(GPMC_SEL_MODE, 32'h03FF_FFFF);
        wr(GPMC_SEL_PULL, 32'h0000_0000);
        tick(3);
        chk16(schmitt_en_c & 16'hE000, 16'h2000);
        low_speed_osc_bypass = 1'b1;
        tick(3);
        chk16(schmitt_en_c & 16'hE000, 16'hA000);
        {low_speed_osc_enable, low_speed_osc_bypass} = 2'b00;
        rtc_timestamp_enable = 1'b1;
        wr(GPMC_SEL_AFH, 32'h9900_0000);
        tick(3);
        chk16({15'h0, rtc_timestamp_in_c}, 16'h0001);
        chk16((pull_up_en_c | pull_dn_en_c) & 16'hC000, 16'h0000);
        rtc_timestamp_enable = 1'b0;
        standby = 1'b1;
        tick(3);
        chk16(pull_dn_en_c & 16'hE000, 16'hE000);
        rtc_owns_pc13 = 1'b1;
        tick(3);
        chk16(pull_dn_en_c & 16'hE000, 16'hC000);
    endtask : t_portc

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        reset = 1'b1;
        reg_sel = GPMC_SEL_MODE;
        debug_config = GPMC_DBG_FULL;
        {reg_wr, reg_wdata, af_out, af_oe, ext_en, ext_val, pin_in_c} = '0;
        {low_speed_osc_enable, low_speed_osc_bypass, rtc_timestamp_enable, standby} = '0;
        {rtc_owns_pc13, injected_trigger_remap, regular_trigger_remap, external_interrupt_lines_inj_trig} = '0;
        {external_interrupt_lines_reg_trig, timer8_channel4, timer8_trigger_out, bad_count, comparisons} = '0;
        repeat (6) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        tick(3);
        t_reset();
        t_input();
        t_output();
        t_setclr();
        t_alt();
        t_analog();
        t_debug();
        t_trig();
        t_portc();
        report_and_stop();
    end
endmodule : gpmc_port_tb
